// ---- hdl/oldc_pkg.sv ----
// constants for the output loop divider configuration register bank
package oldc_pkg;

  // register addresses on the serial programming port
  localparam logic [7:0] ADDR_INT_DIV      = 8'h11;
  localparam logic [7:0] ADDR_BASE_HIGH    = 8'h12;
  localparam logic [7:0] ADDR_BASE_MID     = 8'h13;
  localparam logic [7:0] ADDR_BASE_LOW_CTL = 8'h14;
  localparam logic [7:0] ADDR_NUM_HIGH     = 8'h15;
  localparam logic [7:0] ADDR_NUM_MID      = 8'h16;
  localparam logic [7:0] ADDR_NUM_LOW_MUX  = 8'h17;
  localparam logic [7:0] ADDR_FIRST_DIV    = 8'h18;
  localparam logic [7:0] ADDR_DIV_SRC      = 8'h19;
  localparam logic [7:0] ADDR_RX_BG        = 8'h1a;

  // reset values
  localparam logic [7:0]  RST_INT_DIV     = 8'h00;
  localparam logic [19:0] RST_BASE        = 20'h80000;
  localparam logic [19:0] RST_NUM         = 20'h20000;
  localparam logic [5:0]  RST_FINE_DIV    = 6'h20;
  localparam logic [2:0]  RST_COARSE_DIV  = 3'h0;
  localparam logic [5:0]  RST_SECOND_DIV  = 6'h20;
  localparam logic [4:0]  RST_BG_TRIM     = 5'h00;
  localparam logic [1:0]  RST_TEST_MUX    = 2'h0;

  // bit positions in the control-carrying registers
  localparam int BIT_FREQ_FROM_REGS = 3;
  localparam int BIT_SDM_BYPASS     = 2;
  localparam int BIT_SDM_DISABLE    = 1;
  localparam int BIT_LOOP_RESET     = 0;
  localparam int BIT_TEST_PORT      = 3;
  localparam int BIT_FINE_TOP       = 0;
  localparam int BIT_FIRST_SRC      = 7;
  localparam int BIT_SECOND_SRC     = 6;
  localparam int BIT_RX_RESET       = 7;
  localparam int BIT_RX_PD_ENABLE   = 1;
  localparam int BIT_BG_OVERRIDE    = 0;

  // coarse divider ratio is the code plus this offset
  localparam logic [3:0] COARSE_BASE_RATIO = 4'h4;
  // divider forced while the second output follows the pins
  localparam logic [5:0] SECOND_DIV_PIN_MODE = 6'h01;

  // test mux selections
  typedef enum logic [1:0] {
    OLDC_MUX_FRONT_END = 2'h0,
    OLDC_MUX_PFD_UP    = 2'h1,
    OLDC_MUX_PFD_DOWN  = 2'h2,
    OLDC_MUX_FEEDBACK  = 2'h3
  } oldc_mux_t;

  // receiver reset pulse length
  localparam int CLK_PERIOD_NS     = 40;
  localparam int RX_RESET_NS       = 200;
  localparam int RX_RESET_CYCLES   = (RX_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : oldc_pkg

// ---- hdl/oldc_rx_reset.sv ----
// self-clearing receiver reset pulse generator
`timescale 1ns/10ps

module oldc_rx_reset #(
  parameter int CYCLES = oldc_pkg::RX_RESET_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      active
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;

  // a zero length would leave the counter with no end state
  if (CYCLES < 1)
  begin : g_bad_cycles
    $error("receiver reset length must be at least one cycle");
  end

  // a new start while counting restarts the pulse, so no request is lost
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count  <= '0;
      active <= 1'b0;
    end
    else if (start)
    begin
      count  <= CW'(CYCLES - 1);
      active <= 1'b1;
    end
    else if (count != '0)
    begin
      count  <= count - CW'(1);
    end
    else
    begin
      active <= 1'b0;
    end
  end

endmodule : oldc_rx_reset

// ---- hdl/oldc_regs.sv ----
// output loop divider configuration registers and their steering
`timescale 1ns/10ps

// What this block does
// - holds 8-bit output integer divisor, reset zero; software keeps it at least 64.
// - 20-bit divisor base from three registers, high, mid, upper nibble; resets 524288.
// - 20-bit numerator split the same way as the base; resets to 131072.
// - frequency source bit clear: pins set frequency; set: registers set it.
// - bypass bit set restricts feedback division to integer only.
// - disable bit set stops the output modulator clocks.
// - loop reset bit resets loop counters, leaves output dividers alone.
// - test-port bit clear: lock pin shows lock; set: shows test mux.
// - mux picks front-end clock, up/2, down/2, feedback/2; only with test-port.
// - 6-bit fine divider spans two registers, resets 32, software keeps 1..63.
// - 3-bit coarse divider codes 0..7 mean ratios 4..11, resets to 4.
// - first-output source bit clear: pins set dividers; set: register fields.
// - second-output source clear forces divide by one; set uses register field.
// - second divider field resets 32; software keeps it within 1..63.
// - writing one to receiver reset resets receiver, then clears itself.
// - band gap trim field drives receiver only while override bit set.
// - receiver power-down enable gates both receivers' power-down controls.
module oldc_regs #(
  parameter int RX_RESET_CYCLES = oldc_pkg::RX_RESET_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port from the serial programming engine
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // pins and analog-side status
  input  wire logic [3:0] rate_select,
  input  wire logic       lock_detect,
  input  wire logic       front_end_test_clk,
  input  wire logic       pfd_up,
  input  wire logic       pfd_down,
  input  wire logic       loop_feedback,
  input  wire logic [4:0] bg_auto_trim,
  input  wire logic       primary_pd_req,
  input  wire logic       secondary_pd_req,
  // steering to the output loop
  output logic            freq_from_regs,
  output logic      [3:0] rate_select_sync,
  output logic      [7:0] sdm_integer,
  output logic     [19:0] sdm_divisor_base,
  output logic     [19:0] sdm_numerator,
  output logic            sdm_integer_only,
  output logic            sdm_clock_enable,
  output logic            loop_reset,
  output logic            lock_pin,
  output logic            first_div_from_regs,
  output logic      [5:0] first_output_fine_divider,
  output logic      [3:0] first_output_coarse_ratio,
  output logic            second_div_from_regs,
  output logic      [5:0] second_output_divider,
  output logic            receiver_reset,
  output logic      [4:0] bg_trim,
  output logic            primary_powerdown,
  output logic            secondary_powerdown
);

  // register fields
  logic [7:0]  int_div;
  logic [19:0] base;
  logic [19:0] num;
  logic        freq_src;
  logic        sdm_bypass;
  logic        sdm_disable;
  logic        loop_rst;
  logic        test_port;
  logic [1:0]  test_mux;
  logic [5:0]  fine_div;
  logic [2:0]  coarse_div;
  logic        first_src;
  logic        second_src;
  logic [5:0]  second_div;
  logic [4:0]  bg_field;
  logic        rx_pd_enable;
  logic        bg_override;
  logic        rx_reset_active;

  // pin synchronisers
  logic [3:0]  rate_meta;
  logic [4:0]  probe_meta;
  logic [4:0]  probe_sync;
  logic [3:1]  probe_prev;
  logic [3:1]  probe_half;
  logic [3:0]  probe_pick;
  logic [1:0]  pd_meta;
  logic [1:0]  pd_sync;

  logic        next_lock_pin;
  logic [7:0]  next_rdata;
  logic        rx_reset_req;

  // the pulse counter cannot serve a zero length
  if (RX_RESET_CYCLES < 1)
  begin : g_bad_rx_cycles
    $error("receiver reset cycles must be one or more");
  end

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    addr_hit = (a == target);
  endfunction : addr_hit

  // two flops on every pin before use
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rate_meta        <= 4'h0;
      rate_select_sync <= 4'h0;
      probe_meta       <= 5'h00;
      probe_sync       <= 5'h00;
      pd_meta          <= 2'h0;
      pd_sync          <= 2'h0;
    end
    else
    begin
      rate_meta        <= rate_select;
      rate_select_sync <= rate_meta;
      probe_meta       <= {lock_detect, loop_feedback, pfd_down, pfd_up, front_end_test_clk};
      probe_sync       <= probe_meta;
      pd_meta          <= {secondary_pd_req, primary_pd_req};
      pd_sync          <= pd_meta;
    end
  end

  // divide-by-two of the up, down and feedback probe signals, toggling on each rising edge
  generate
    for (genvar i = 1; i < 4; i++)
    begin : g_half
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          probe_prev[i] <= 1'b0;
          probe_half[i] <= 1'b0;
        end
        else
        begin
          probe_prev[i] <= probe_sync[i];
          if (probe_sync[i] && !probe_prev[i])
            probe_half[i] <= ~probe_half[i];
        end
      end
    end
  endgenerate

  // front-end test clock is passed undivided
  assign probe_pick = {probe_half, probe_sync[0]};

  // divisor words; each byte takes effect alone, software orders its writes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      int_div <= oldc_pkg::RST_INT_DIV;
      base    <= oldc_pkg::RST_BASE;
      num     <= oldc_pkg::RST_NUM;
    end
    else if (reg_wr)
    begin
      if (addr_hit(reg_addr, oldc_pkg::ADDR_INT_DIV))
        int_div <= reg_wdata;
      if (addr_hit(reg_addr, oldc_pkg::ADDR_BASE_HIGH))
        base[19:12] <= reg_wdata;
      if (addr_hit(reg_addr, oldc_pkg::ADDR_BASE_MID))
        base[11:4] <= reg_wdata;
      if (addr_hit(reg_addr, oldc_pkg::ADDR_BASE_LOW_CTL))
        base[3:0] <= reg_wdata[7:4];
      if (addr_hit(reg_addr, oldc_pkg::ADDR_NUM_HIGH))
        num[19:12] <= reg_wdata;
      if (addr_hit(reg_addr, oldc_pkg::ADDR_NUM_MID))
        num[11:4] <= reg_wdata;
      if (addr_hit(reg_addr, oldc_pkg::ADDR_NUM_LOW_MUX))
        num[3:0] <= reg_wdata[7:4];
    end
  end

  // control fields and output dividers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      freq_src     <= 1'b0;
      sdm_bypass   <= 1'b0;
      sdm_disable  <= 1'b0;
      loop_rst     <= 1'b0;
      test_port    <= 1'b0;
      test_mux     <= oldc_pkg::RST_TEST_MUX;
      fine_div     <= oldc_pkg::RST_FINE_DIV;
      coarse_div   <= oldc_pkg::RST_COARSE_DIV;
      first_src    <= 1'b0;
      second_src   <= 1'b0;
      second_div   <= oldc_pkg::RST_SECOND_DIV;
      bg_field     <= oldc_pkg::RST_BG_TRIM;
      rx_pd_enable <= 1'b0;
      bg_override  <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (addr_hit(reg_addr, oldc_pkg::ADDR_BASE_LOW_CTL))
      begin
        freq_src    <= reg_wdata[oldc_pkg::BIT_FREQ_FROM_REGS];
        sdm_bypass  <= reg_wdata[oldc_pkg::BIT_SDM_BYPASS];
        sdm_disable <= reg_wdata[oldc_pkg::BIT_SDM_DISABLE];
        loop_rst    <= reg_wdata[oldc_pkg::BIT_LOOP_RESET];
      end
      if (addr_hit(reg_addr, oldc_pkg::ADDR_NUM_LOW_MUX))
      begin
        test_port   <= reg_wdata[oldc_pkg::BIT_TEST_PORT];
        test_mux    <= reg_wdata[2:1];
        fine_div[5] <= reg_wdata[oldc_pkg::BIT_FINE_TOP];
      end
      if (addr_hit(reg_addr, oldc_pkg::ADDR_FIRST_DIV))
      begin
        fine_div[4:0] <= reg_wdata[7:3];
        coarse_div    <= reg_wdata[2:0];
      end
      if (addr_hit(reg_addr, oldc_pkg::ADDR_DIV_SRC))
      begin
        first_src  <= reg_wdata[oldc_pkg::BIT_FIRST_SRC];
        second_src <= reg_wdata[oldc_pkg::BIT_SECOND_SRC];
        second_div <= reg_wdata[5:0];
      end
      if (addr_hit(reg_addr, oldc_pkg::ADDR_RX_BG))
      begin
        bg_field     <= reg_wdata[6:2];
        rx_pd_enable <= reg_wdata[oldc_pkg::BIT_RX_PD_ENABLE];
        bg_override  <= reg_wdata[oldc_pkg::BIT_BG_OVERRIDE];
      end
    end
  end

  // a zero in the reset bit leaves a running pulse alone
  assign rx_reset_req = reg_wr && addr_hit(reg_addr, oldc_pkg::ADDR_RX_BG)
                        && reg_wdata[oldc_pkg::BIT_RX_RESET];

  // writing one to the reset bit starts a timed pulse that ends by itself
  oldc_rx_reset #(
    .CYCLES (RX_RESET_CYCLES)
  ) u_rx_reset (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (rx_reset_req),
    .active (rx_reset_active)
  );

  // lock pin source
  always_comb
  begin
    next_lock_pin = probe_sync[4];
    if (test_port)
    begin
      unique case (oldc_pkg::oldc_mux_t'(test_mux))
        oldc_pkg::OLDC_MUX_FRONT_END: next_lock_pin = probe_pick[0];
        oldc_pkg::OLDC_MUX_PFD_UP:    next_lock_pin = probe_pick[1];
        oldc_pkg::OLDC_MUX_PFD_DOWN:  next_lock_pin = probe_pick[2];
        oldc_pkg::OLDC_MUX_FEEDBACK:  next_lock_pin = probe_pick[3];
      endcase
    end
  end

  // read back; the reset bit shows the pulse still in progress
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      oldc_pkg::ADDR_INT_DIV:      next_rdata = int_div;
      oldc_pkg::ADDR_BASE_HIGH:    next_rdata = base[19:12];
      oldc_pkg::ADDR_BASE_MID:     next_rdata = base[11:4];
      oldc_pkg::ADDR_BASE_LOW_CTL: next_rdata = {base[3:0], freq_src, sdm_bypass,
                                                 sdm_disable, loop_rst};
      oldc_pkg::ADDR_NUM_HIGH:     next_rdata = num[19:12];
      oldc_pkg::ADDR_NUM_MID:      next_rdata = num[11:4];
      oldc_pkg::ADDR_NUM_LOW_MUX:  next_rdata = {num[3:0], test_port, test_mux, fine_div[5]};
      oldc_pkg::ADDR_FIRST_DIV:    next_rdata = {fine_div[4:0], coarse_div};
      oldc_pkg::ADDR_DIV_SRC:      next_rdata = {first_src, second_src, second_div};
      oldc_pkg::ADDR_RX_BG:        next_rdata = {rx_reset_active, bg_field,
                                                 rx_pd_enable, bg_override};
      default:                     next_rdata = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // all steering outputs registered
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      freq_from_regs            <= 1'b0;
      sdm_integer               <= oldc_pkg::RST_INT_DIV;
      sdm_divisor_base          <= oldc_pkg::RST_BASE;
      sdm_numerator             <= oldc_pkg::RST_NUM;
      sdm_integer_only          <= 1'b0;
      sdm_clock_enable          <= 1'b1;
      loop_reset                <= 1'b0;
      lock_pin                  <= 1'b0;
      first_div_from_regs       <= 1'b0;
      first_output_fine_divider <= oldc_pkg::RST_FINE_DIV;
      first_output_coarse_ratio <= oldc_pkg::COARSE_BASE_RATIO;
      second_div_from_regs      <= 1'b0;
      second_output_divider     <= oldc_pkg::SECOND_DIV_PIN_MODE;
      receiver_reset            <= 1'b0;
      bg_trim                   <= oldc_pkg::RST_BG_TRIM;
      primary_powerdown         <= 1'b0;
      secondary_powerdown       <= 1'b0;
    end
    else
    begin
      // loop consumers use register values only when freq_from_regs is high
      freq_from_regs            <= freq_src;
      sdm_integer               <= int_div;
      sdm_divisor_base          <= base;
      sdm_numerator             <= num;
      sdm_integer_only          <= sdm_bypass;
      sdm_clock_enable          <= ~sdm_disable;
      loop_reset                <= loop_rst;
      lock_pin                  <= next_lock_pin;
      first_div_from_regs       <= first_src;
      first_output_fine_divider <= fine_div;
      first_output_coarse_ratio <= {1'b0, coarse_div} + oldc_pkg::COARSE_BASE_RATIO;
      second_div_from_regs      <= second_src;
      second_output_divider     <= second_src ? second_div
                                              : oldc_pkg::SECOND_DIV_PIN_MODE;
      receiver_reset            <= rx_reset_active;
      // auto trim is made on this clock, so it needs no synchroniser
      bg_trim                   <= bg_override ? bg_field : bg_auto_trim;
      primary_powerdown         <= rx_pd_enable & pd_sync[0];
      secondary_powerdown       <= rx_pd_enable & pd_sync[1];
    end
  end

endmodule : oldc_regs

// ---- verification/oldc_regs_sva.sv ----
// assertion checker for the output loop divider register bank
`timescale 1ns/10ps
module oldc_regs_sva #(
  parameter int RX_RESET_CYCLES = 5
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       freq_from_regs,
  input wire logic [7:0] sdm_integer,
  input wire logic       sdm_integer_only,
  input wire logic       sdm_clock_enable,
  input wire logic       loop_reset,
  input wire logic       first_div_from_regs,
  input wire logic [5:0] first_output_fine_divider,
  input wire logic [3:0] first_output_coarse_ratio,
  input wire logic       second_div_from_regs,
  input wire logic [5:0] second_output_divider,
  input wire logic       receiver_reset,
  input wire logic [4:0] bg_trim
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // steering lags a write by two edges, so keep write data that long
  logic [7:0] wd1, wd2;
  int         rx_len;
  always_ff @(posedge clk)
  begin
    wd1    <= reg_wdata;
    wd2    <= wd1;
    rx_len <= (!rst_n || !receiver_reset) ? 0 : rx_len + 1;
  end
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_rx_req;
    s_wr(oldc_pkg::ADDR_RX_BG) ##0 reg_wdata[7];
  endsequence
  property p_reset_vals;
    $rose(rst_n) |-> sdm_integer == 8'h00 && sdm_clock_enable
      && first_output_fine_divider == 6'h20 && first_output_coarse_ratio == 4'h4;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  property p_int;
    s_wr(oldc_pkg::ADDR_INT_DIV) |=> ##1 sdm_integer == wd2;
  endproperty
  a_int: assert property (p_int) else $error("integer divisor not taken");
  property p_ctl;
    s_wr(oldc_pkg::ADDR_BASE_LOW_CTL) |=> ##1 freq_from_regs == wd2[3]
      && sdm_integer_only == wd2[2] && sdm_clock_enable == !wd2[1] && loop_reset == wd2[0];
  endproperty
  a_ctl: assert property (p_ctl) else $error("loop control bits wrong");
  property p_first;
    s_wr(oldc_pkg::ADDR_FIRST_DIV) |=> ##1 first_output_fine_divider[4:0] == wd2[7:3]
      && first_output_coarse_ratio == {1'b0, wd2[2:0]} + 4'h4;
  endproperty
  a_first: assert property (p_first) else $error("first output dividers wrong");
  property p_src;
    s_wr(oldc_pkg::ADDR_DIV_SRC) |=> ##1 first_div_from_regs == wd2[7]
      && second_div_from_regs == wd2[6] && second_output_divider == (wd2[6] ? wd2[5:0] : 6'h01);
  endproperty
  a_src: assert property (p_src) else $error("divider source wrong");
  property p_bg;
    s_wr(oldc_pkg::ADDR_RX_BG) ##0 reg_wdata[0] |=> ##1 bg_trim == wd2[6:2];
  endproperty
  a_bg: assert property (p_bg) else $error("band gap trim not applied");
  property p_rx_start;
    s_rx_req |=> !receiver_reset ##1 receiver_reset[*5];
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("receiver reset pulse wrong");
  property p_rx_len;
    $fell(receiver_reset) |-> rx_len >= RX_RESET_CYCLES;
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("receiver reset too short");
endmodule : oldc_regs_sva
bind oldc_regs oldc_regs_sva #(.RX_RESET_CYCLES(RX_RESET_CYCLES)) u_sva (
  .clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .freq_from_regs, .sdm_integer,
  .sdm_integer_only, .sdm_clock_enable, .loop_reset, .first_div_from_regs,
  .first_output_fine_divider, .first_output_coarse_ratio, .second_div_from_regs,
  .second_output_divider, .receiver_reset, .bg_trim
);

// ---- verification/oldc_host.sv ----
// host software model on the register port
`timescale 1ns/10ps
module oldc_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // last fine divider halves, so a split write never leaves it zero
  logic [7:0] h17 = 8'h01;
  logic [7:0] h18 = 8'h00;
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h11 && v < 8'h40)
      v[6] = 1'b1;
    if (a == 8'h17 && !v[0] && h18[7:3] == 5'h00)
      v[0] = 1'b1;
    if (a == 8'h18 && !h17[0] && v[7:3] == 5'h00)
      v[3] = 1'b1;
    if (a == 8'h19 && v[5:0] == 6'h00)
      v[0] = 1'b1;
    return v;
  endfunction : legal
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    if (a == 8'h17)
      h17 = d;
    if (a == 8'h18)
      h18 = d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : oldc_host

// ---- verification/test_output_loop_divider_config.sv ----
// self-checking bench for the output loop divider register bank
`timescale 1ns/10ps
module test_output_loop_divider_config;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, a, d, rd_v, sdm_integer;
  logic        reg_wr, reg_rd, freq_from_regs, sdm_integer_only, sdm_clock_enable, v;
  logic        loop_reset, lock_pin, first_div_from_regs, second_div_from_regs;
  logic        receiver_reset, primary_powerdown, secondary_powerdown;
  logic        lock_detect = 1'b0;
  logic        front_end_test_clk = 1'b0;
  logic        pfd_up = 1'b0;
  logic        pfd_down = 1'b0;
  logic        loop_feedback = 1'b0;
  logic        primary_pd_req = 1'b0;
  logic        secondary_pd_req = 1'b0;
  logic [3:0]  rate_select = 4'h5;
  logic [4:0]  bg_auto_trim = 5'h0a;
  logic [3:0]  rate_select_sync, first_output_coarse_ratio;
  logic [4:0]  bg_trim;
  logic [5:0]  first_output_fine_divider, second_output_divider;
  logic [19:0] sdm_divisor_base, sdm_numerator;
  logic [7:0]  mem [8'h11:8'h1a];
  logic [15:0] corner [4] = '{16'h1140, 16'h18ff, 16'h197f, 16'h1a7d};
  int          error_cnt = 0;
  int          tests_run = 0;
  int          seed = 32'h4012948f;
  always #20 clk = ~clk;
  oldc_host host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  oldc_regs dut (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .rate_select, .lock_detect, .front_end_test_clk, .pfd_up, .pfd_down, .loop_feedback,
    .bg_auto_trim, .primary_pd_req, .secondary_pd_req, .freq_from_regs, .rate_select_sync,
    .sdm_integer, .sdm_divisor_base, .sdm_numerator, .sdm_integer_only, .sdm_clock_enable,
    .loop_reset, .lock_pin, .first_div_from_regs, .first_output_fine_divider,
    .first_output_coarse_ratio, .second_div_from_regs, .second_output_divider,
    .receiver_reset, .bg_trim, .primary_powerdown, .secondary_powerdown);
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chkr(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chkr
  task automatic check_outs;
    chk("int", mem[8'h11], sdm_integer);
    chk("base", {mem[8'h12], mem[8'h13], mem[8'h14][7:4]}, sdm_divisor_base);
    chk("num", {mem[8'h15], mem[8'h16], mem[8'h17][7:4]}, sdm_numerator);
    chk("fsrc", mem[8'h14][3], freq_from_regs);
    chk("pins", rate_select, rate_select_sync);
    chk("bypass", mem[8'h14][2], sdm_integer_only);
    chk("sdmclk", !mem[8'h14][1], sdm_clock_enable);
    chk("lrst", mem[8'h14][0], loop_reset);
    chk("fine", {mem[8'h17][0], mem[8'h18][7:3]}, first_output_fine_divider);
    chk("coarse", mem[8'h18][2:0] + 4'h4, first_output_coarse_ratio);
    chk("src1", mem[8'h19][7], first_div_from_regs);
    chk("src2", mem[8'h19][6], second_div_from_regs);
    chk("div2", mem[8'h19][6] ? mem[8'h19][5:0] : 6'h01, second_output_divider);
    chk("bg", mem[8'h1a][0] ? mem[8'h1a][6:2] : bg_auto_trim, bg_trim);
    chk("pd", {primary_pd_req, secondary_pd_req} & {2{mem[8'h1a][1]}},
        {primary_powerdown, secondary_powerdown});
  endtask : check_outs
  task automatic read_all;
    for (int i = 8'h11; i <= 8'h1a; i++)
    begin
      host.rd(i[7:0], rd_v);
      chkr("reg", mem[i], rd_v);
    end
  endtask : read_all
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial
  begin
    #(40 * 10000);
    error_cnt++;
    complete_run;
  end
  initial
  begin
    mem = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h20, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00};
    settle(20);
    rst_n = 1'b1;
    settle(3);
    check_outs;
    read_all;
    $display("test reset done");
    for (int i = 0; i < 44; i++)
    begin
      a = (i < 4) ? corner[i][15:8] : 8'h11 + 8'($unsigned($random(seed)) % 32'd10);
      d = (i < 4) ? corner[i][7:0] : host.legal(a, 8'($random(seed)));
      if (a == 8'h1a)
        d[7] = 1'b0;
      {rate_select, lock_detect, primary_pd_req, secondary_pd_req} = 7'($random(seed));
      bg_auto_trim = 5'($random(seed));
      host.wr(a, d);
      mem[a] = d;
      settle(3);
      check_outs;
      host.rd(a, rd_v);
      chkr("rdback", mem[a], rd_v);
    end
    $display("test random done");
    host.wr(8'h10, 8'hff);
    host.wr(8'h1b, 8'hff);
    host.rd(8'h10, rd_v);
    chkr("unmapped", 8'h00, rd_v);
    host.rd(8'h1b, rd_v);
    chkr("unmapped", 8'h00, rd_v);
    check_outs;
    $display("test unmapped done");
    mem[8'h17] = {mem[8'h17][7:4], 3'b000, mem[8'h17][0]};
    host.wr(8'h17, mem[8'h17]);
    lock_detect = 1'b1;
    settle(4);
    chk("lock", 1'b1, lock_pin);
    for (int m = 0; m < 4; m++)
    begin
      mem[8'h17] = {mem[8'h17][7:4], 1'b1, 2'(m), mem[8'h17][0]};
      host.wr(8'h17, mem[8'h17]);
      settle(4);
      v = lock_pin;
      {loop_feedback, pfd_down, pfd_up, front_end_test_clk} = 4'b0001 << m;
      settle(5);
      chk("probe", (m == 0) ? 1'b1 : !v, lock_pin);
      {loop_feedback, pfd_down, pfd_up, front_end_test_clk} = 4'b0000;
      settle(5);
      chk("probe", (m == 0) ? 1'b0 : !v, lock_pin);
    end
    $display("test lock pin done");
    host.wr(8'h1a, mem[8'h1a] | 8'h80);
    host.rd(8'h1a, rd_v);
    chkr("rxbit", mem[8'h1a] | 8'h80, rd_v);
    chk("rxrst", 1'b1, receiver_reset);
    settle(8);
    chk("rxrst", 1'b0, receiver_reset);
    host.rd(8'h1a, rd_v);
    chkr("rxbit", mem[8'h1a], rd_v);
    $display("test receiver reset done");
    complete_run;
  end
endmodule : test_output_loop_divider_config
